// ===== bench/pioe_assertions.sv
module pioe_assertions (
  // clock and reset
  input logic sys_clk,
  input logic rst_b,
  // configuration
  input pioe_pkg::pioe_cfg_s cfg,
  // fabric side
  input logic core_load,
  input logic core_dout,
  input logic core_oe,
  input logic core_clr,
  input logic core_pre,
  input logic reg_q,
  input pioe_pkg::pioe_route_s route_out,
  // pin side
  input logic pin_in,
  input logic pin_out,
  input logic pin_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import pioe_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_powerup_level: assert property ($rose(rst_b) |-> reg_q == cfg.powerup_high) else $error("powerup");
  a_clr_forces_low: assert property (core_clr && !cfg.powerup_high |=> !reg_q) else $error("clear");
  a_base_ignores: assert property (cfg.powerup_high && !cfg.enhanced && !core_load |=> $stable(reg_q))
    else $error("base force");
  a_pre_forces_high: assert property (core_pre && cfg.powerup_high && cfg.enhanced |=> reg_q)
    else $error("preset");
  a_od_release: assert property (cfg.enhanced && cfg.open_drain && core_oe && core_load && !core_clr
    && !core_pre |=> !pin_out && pin_oe == !$past(core_dout)) else $error("open drain");
  a_column_only: assert property (cfg.is_column |-> route_out[2:0] == 3'h0) else $error("column");
  a_row_fanout: assert property ((!cfg.is_column && !cfg.reg_is_output && core_load && pin_in
    && !core_clr && !core_pre)[*3] |=> route_out == 4'hF) else $error("row");
  a_out_load: assert property (cfg.reg_is_output && core_load && !core_clr && !core_pre
    |=> reg_q == $past(core_dout)) else $error("load");
endmodule : pioe_assertions

// ===== bench/pioe_pin_model.sv
module pioe_pin_model (
  // element drive
  input logic pin_out,
  input logic pin_oe,
  // far-side driver
  input logic ext_en,
  input logic ext_val,
  // line level seen by the element
  output logic pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // pull-up when nobody drives the line
  assign pin_in = pin_oe ? pin_out : (ext_en ? ext_val : 1'b1);
endmodule : pioe_pin_model

// ===== bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pioe_pkg::*;
  logic sys_clk = 0, rst_b = 0, core_load = 0, core_dout = 0, core_oe = 0, core_clr = 0, core_pre = 0;
  logic ext_en = 0, ext_val = 0, reg_q, pin_in, pin_out, pin_oe;
  pioe_cfg_s cfg = '0;
  pioe_route_s route_out;
  int err_count = 0, n_tests = 0;
  always #12.5 sys_clk = ~sys_clk;
  pioe_top dut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .cfg(cfg),
    .core_load(core_load),
    .core_dout(core_dout),
    .core_oe(core_oe),
    .core_clr(core_clr),
    .core_pre(core_pre),
    .reg_q(reg_q),
    .route_out(route_out),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );
  pioe_pin_model u_pin (
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .ext_en(ext_en),
    .ext_val(ext_val),
    .pin_in(pin_in)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic start(input pioe_cfg_s c);
    @(negedge sys_clk);
    {rst_b, core_load, core_dout, core_oe, core_clr, core_pre, ext_en} = '0;
    cfg = c;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    chk({3'h0, reg_q}, {3'h0, c.powerup_high});
  endtask : start
  // load, dout, clr, pre, oe for one clock
  task automatic step(input logic [4:0] v);
    {core_load, core_dout, core_clr, core_pre, core_oe} = v;
    @(negedge sys_clk);
  endtask : step
  task automatic t_clr;
    start(5'h02);
    step(5'h18);
    chk({3'h0, reg_q}, 4'h1);
    step(5'h1C);
    chk({3'h0, reg_q}, 4'h0);
    step(5'h1C);
    chk({3'h0, reg_q}, 4'h0);
    $display("t_clr done");
  endtask : t_clr
  task automatic t_pre;
    for (int e = 0; e < 2; e++) begin
      start({1'b1, e[0], 3'h2});
      step(5'h18);
      step(5'h04);
      chk({3'h0, reg_q}, 4'h1);
      step(5'h12);
      chk({3'h0, reg_q}, {3'h0, e[0]});
    end
    $display("t_pre done");
  endtask : t_pre
  task automatic t_od;
    for (int e = 0; e < 2; e++) begin
      start({1'b0, e[0], 3'h6});
      step(5'h11);
      chk({2'h0, pin_out, pin_oe}, 4'h1);
      step(5'h19);
      chk({2'h0, pin_out, pin_oe}, e ? 4'h0 : 4'h3);
    end
    $display("t_od done");
  endtask : t_od
  task automatic t_route;
    for (int c = 0; c < 2; c++) begin
      start({4'h0, c[0]});
      {ext_en, ext_val} = 2'h3;
      repeat (3) step(5'h10);
      chk(route_out, c ? 4'h8 : 4'hF);
      chk({3'h0, reg_q}, 4'h1);
      {ext_en, ext_val} = 2'h2;
      repeat (3) step(5'h10);
      chk(route_out, 4'h0);
      chk({3'h0, reg_q}, 4'h0);
    end
    $display("t_route done");
  endtask : t_route
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    t_clr();
    t_pre();
    t_od();
    t_route();
    end_of_test();
  end
endmodule : tb_top
bind pioe_top pioe_assertions u_chk (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .cfg(cfg),
  .core_load(core_load),
  .core_dout(core_dout),
  .core_oe(core_oe),
  .core_clr(core_clr),
  .core_pre(core_pre),
  .reg_q(reg_q),
  .route_out(route_out),
  .pin_in(pin_in),
  .pin_out(pin_out),
  .pin_oe(pin_oe)
);

// ===== hw/pioe_top.sv
// Notes on behaviour
// - After configuration the register holds the configured level until it is clocked or forced.
// - A register that starts low is forced low by the clear input.
// - In the base variant a register that starts high ignores both clear and preset.
// - In the enhanced variant a register that starts high is forced high by the preset input.
// - The enhanced element offers open-drain output that drives only low and releases for high.
// - A row element feeds local, cluster, row and column routing; a column element feeds column only.
// - The single register serves either as the input capture or as the output register.
module pioe_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration
  input wire pioe_pkg::pioe_cfg_s cfg,
  // fabric side
  input wire logic core_load,
  input wire logic core_dout,
  input wire logic core_oe,
  input wire logic core_clr,
  input wire logic core_pre,
  output logic reg_q,
  output pioe_pkg::pioe_route_s route_out,
  // pin side
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe
);
  import pioe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser
  logic sync1_reg;
  logic sync2_reg;
  logic sync1_next;
  logic sync2_next;

  always_comb begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sync1_reg <= RST_SYNC;
      sync2_reg <= RST_SYNC;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // clear is honoured only by a register that starts low
  function automatic logic clr_allowed(input pioe_cfg_s c, input logic clr);
    clr_allowed = clr && !c.powerup_high;
  endfunction : clr_allowed

  // preset is honoured only by an enhanced register that starts high
  function automatic logic pre_allowed(input pioe_cfg_s c, input logic pre);
    pre_allowed = pre && c.powerup_high && c.enhanced;
  endfunction : pre_allowed

  // open-drain drive exists only in the enhanced element
  function automatic logic od_active(input pioe_cfg_s c);
    od_active = c.enhanced && c.open_drain;
  endfunction : od_active

  // spread one level over the routing levels that this element may reach
  function automatic pioe_route_s fan_out(input logic is_column, input logic level);
    pioe_route_s r;
    r = ROUTE_NONE;
    r[ROUTE_COLUMN_POS] = level;
    if (!is_column) begin
      r[ROUTE_ROW_POS] = level;
      r[ROUTE_CLUSTER_POS] = level;
      r[ROUTE_LOCAL_POS] = level;
    end
    fan_out = r;
  endfunction : fan_out

  ////////////////////////////////////////////////////////////////////////////
  // element register
  logic q_reg;
  logic q_next;
  logic clr_ok;
  logic pre_ok;
  logic load_val;

  always_comb begin
    // forces are priority terms on the clock, so a force shows one edge after it is raised
    clr_ok = clr_allowed(cfg, core_clr);
    pre_ok = pre_allowed(cfg, core_pre);
    // one register, shared between capture duty and output duty
    load_val = cfg.reg_is_output ? core_dout : sync2_reg;
    if (clr_ok) begin
      q_next = CLR_LEVEL;
    end else if (pre_ok) begin
      q_next = PRE_LEVEL;
    end else if (core_load) begin
      q_next = load_val;
    end else begin
      q_next = q_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      // configuration in progress: take the chosen power-up level
      q_reg <= cfg.powerup_high;
    end else begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  logic out_reg;
  logic out_next;
  logic oe_reg;
  logic oe_next;
  logic drive_val;

  always_comb begin
    // registered value in output mode, direct core data otherwise
    drive_val = cfg.reg_is_output ? q_next : core_dout;
    if (od_active(cfg)) begin
      // only low is driven; a high is left to the line's pull-up
      out_next = CLR_LEVEL;
      oe_next = core_oe && !drive_val;
    end else begin
      out_next = drive_val;
      oe_next = core_oe;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      // the pin stays released while configuration is in progress
      out_reg <= RST_OUT;
      oe_reg <= RST_OE;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input fan-out
  pioe_route_s route_reg;
  pioe_route_s route_next;
  logic route_level;

  always_comb begin
    // captured value in input mode, the synchronised pin in output mode
    route_level = cfg.reg_is_output ? sync2_reg : q_next;
    route_next = fan_out(cfg.is_column, route_level);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      route_reg <= ROUTE_NONE;
    end else begin
      route_reg <= route_next;
    end
  end

  always_comb begin
    reg_q = q_reg;
    route_out = route_reg;
    pin_out = out_reg;
    pin_oe = oe_reg;
  end

endmodule : pioe_top

// ===== shared/pioe_pkg.sv
package pioe_pkg;

  // reset values of the pin-side flops
  localparam logic RST_OE = 1'h0;
  localparam logic RST_OUT = 1'h0;
  localparam logic RST_SYNC = 1'h0;

  // forced levels of the clear and preset controls, which act on the clock edge
  localparam logic CLR_LEVEL = 1'h0;
  localparam logic PRE_LEVEL = 1'h1;

  // bit positions of the routing fan-out word
  localparam int ROUTE_LOCAL_POS = 0;
  localparam int ROUTE_CLUSTER_POS = 1;
  localparam int ROUTE_ROW_POS = 2;
  localparam int ROUTE_COLUMN_POS = 3;

  // static configuration of one pin element
  typedef struct packed {
    logic powerup_high;
    logic enhanced;
    logic open_drain;
    logic reg_is_output;
    logic is_column;
  } pioe_cfg_s;

  // copies of the captured input sent to each routing level
  typedef struct packed {
    logic column;
    logic row;
    logic cluster;
    logic local_route;
  } pioe_route_s;

  localparam pioe_route_s ROUTE_NONE = 4'h0;

endpackage : pioe_pkg
